/* sras_pkg.sv */
/*
 * Shared constants and types of the serial register access slave.
 * Assumes nothing of its surroundings; the slave and the bench refer to it by scoped names.
 */
package sras_pkg;

	// Command byte field positions
	localparam int CMD_DIR_BIT = 0;
	localparam int CMD_MODE_LSB = 1;
	localparam int CMD_COUNT_LSB = 3;

	// Command field encodings
	localparam logic [4:0] COUNT_UNLIMITED = 5'h1f;
	localparam logic [4:0] COUNT_LAST = 5'h01;
	localparam logic [1:0] STEP_KEEP = 2'h0;
	localparam logic [1:0] STEP_ONE = 2'h1;
	localparam logic [1:0] STEP_ROW = 2'h2;
	localparam logic [7:0] INC_ONE = 8'h01;
	localparam logic [7:0] INC_ROW = 8'h20;
	localparam logic [7:0] INC_NONE = 8'h00;

	// Reserved address range, only ever written with zero
	localparam logic [7:0] RSVD_LO = 8'h20;
	localparam logic [7:0] RSVD_HI = 8'h7f;

	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_FIRST = 3'h0;

	// Reset values
	localparam logic [7:0] TX_RESET = 8'h00;
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic [4:0] COUNT_RESET = 5'h00;

	typedef struct packed {
		logic line_input_level;
		logic receive_data_available;
		logic error;
		logic frame_mode;
	} sras_status_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} sras_wr_type;

	typedef enum logic [1:0] {
		ST_ADDR = 2'b00,
		ST_CMD = 2'b01,
		ST_DATA = 2'b11
	} sras_state_type;

	function automatic logic [7:0] step_of(input logic [1:0] mode);
		unique case (mode)
			STEP_ONE: step_of = INC_ONE;
			STEP_ROW: step_of = INC_ROW;
			default: step_of = INC_NONE;
		endcase
	endfunction

	function automatic logic is_reserved(input logic [7:0] addr);
		is_reserved = (addr >= RSVD_LO) && (addr <= RSVD_HI);
	endfunction

endpackage

/* sras_sync.sv */
/*
 * Two flip-flop synchroniser for a group of pin levels.
 * Assumes inputs are asynchronous to clk; reset value set by parameter.
 */
`timescale 1ns/10ps
`default_nettype none

module sras_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] q_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_ff <= RST_VAL;
			q_ff <= RST_VAL;
		end else begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule // sras_sync

`default_nettype wire

/* sras_fifo2.sv */
/*
 * Two-entry buffer with valid/ready on both sides; head always in slot 0.
 * Assumes one clock; outputs come straight from flip-flops.
 */
`timescale 1ns/10ps
`default_nettype none

module sras_fifo2 #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] slot_ff [2];
	logic [1:0] full_ff;
	logic [WIDTH-1:0] nxt_slot [2];
	logic [1:0] nxt_full;
	logic pop;
	logic push;

	always_comb begin
		pop = full_ff[0] && out_ready;
		push = in_valid && !full_ff[1];
		nxt_slot[0] = slot_ff[0];
		nxt_slot[1] = slot_ff[1];
		nxt_full = full_ff;
		if (pop) begin
			nxt_slot[0] = slot_ff[1];
			nxt_full = {1'b0, full_ff[1]};
		end
		if (push) begin
			if (!nxt_full[0]) begin
				nxt_slot[0] = in_data;
				nxt_full[0] = 1'b1;
			end else begin
				nxt_slot[1] = in_data;
				nxt_full[1] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			full_ff <= 2'h0;
			slot_ff[0] <= '0;
			slot_ff[1] <= '0;
		end else begin
			full_ff <= nxt_full;
			slot_ff[0] <= nxt_slot[0];
			slot_ff[1] <= nxt_slot[1];
		end
	end

	assign in_ready = !full_ff[1];
	assign out_valid = full_ff[0];
	assign out_data = slot_ff[0];
endmodule // sras_fifo2

`default_nettype wire

/* sras_slave.sv */
/*
 * Serial register access slave: an external master reads and writes a 256 x 8 register
 * space through select, clock, data-in and data-out pins; status nibbles lead every frame.
 * Assumes pins asynchronous to mclk (200 MHz) and a serial clock of at most ~12.5 MHz;
 * the register file answers rd_data combinationally from rd_addr within a few cycles.
 */
// Overview of operation
// - Slave in mode 0: clock idles low, input sampled on rising edge.
// - Frame starts at select fall; address byte then command byte follow.
// - Input bits captured on rising serial clock edges, most significant first.
// - Command bit 0 set means read frame, clear means write frame.
// - Command bits 7..3 give data byte count; 31 means until select rises.
// - Command bits 2..1 step address: keep, plus one, plus 32; 3 also keeps.
// - Frame ends at select rise or count reached; low select chains frames.
// - Read data MSB appears after first falling edge following command LSB.
// - Multi-byte read steps the address before the next register shifts out.
// - First two output bytes of every frame carry all four channel status.
// - Write byte captured at its LSB with the old address; address stepped in that same cycle.
// - Write frame output carries status for 16 clocks, then zero.
// - Select rise with clock idle aborts; a partial byte or command is discarded.
// - 256 eight-bit registers; reserved ones receive only zero.
// - Nibble: level, data available, error, mode; bytes hold ch3/ch2, ch1/ch0.
`timescale 1ns/10ps
`default_nettype none

module sras_slave (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic select_low_pin,
	input wire logic serial_clock_pin,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	output logic serial_out_en,
	output logic frame_active,
	input wire sras_pkg::sras_status_type [3:0] chan_status,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data,
	output logic rd_strobe,
	output logic wr_valid,
	input wire logic wr_ready,
	output sras_pkg::sras_wr_type wr_entry,
	output logic wr_overrun
);
	logic s_sel;
	logic s_sclk;
	logic s_sdi;
	logic prev_sel_ff;
	logic prev_sclk_ff;
	logic sel_low;
	logic sel_fall;
	logic sclk_rise;
	logic sclk_fall;

	sras_pkg::sras_state_type state_ff, nxt_state;
	logic [2:0] bitcnt_ff, nxt_bitcnt;
	logic [6:0] shin_ff, nxt_shin;
	logic [7:0] tx_ff, nxt_tx;
	logic [7:0] addr_ff, nxt_addr;
	logic dir_ff, nxt_dir;
	logic [1:0] mode_ff, nxt_mode;
	logic [4:0] count_ff, nxt_count;
	logic [4:0] remain_ff, nxt_remain;
	logic push_ff, nxt_push;
	sras_pkg::sras_wr_type entry_ff, nxt_entry;
	logic rd_strobe_ff, nxt_rd_strobe;
	logic overrun_ff, nxt_overrun;
	logic oen_ff, nxt_oen;
	logic fifo_in_ready;
	logic [7:0] byte_in;
	logic [15:0] fifo_out;

	// Select idles high, so it resets high to avoid a phantom frame
	sras_sync #(
		.WIDTH(3),
		.RST_VAL(3'h4)
	) u_sync (
		.clk(mclk),
		.rst(sys_rst),
		.d({select_low_pin, serial_clock_pin, serial_in_pin}),
		.q({s_sel, s_sclk, s_sdi})
	);

	always_comb begin
		sel_low = !s_sel;
		sel_fall = !s_sel && prev_sel_ff;
		sclk_rise = s_sclk && !prev_sclk_ff;
		sclk_fall = !s_sclk && prev_sclk_ff;
		byte_in = {shin_ff, s_sdi};
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_bitcnt = bitcnt_ff;
		nxt_shin = shin_ff;
		nxt_tx = tx_ff;
		nxt_addr = addr_ff;
		nxt_dir = dir_ff;
		nxt_mode = mode_ff;
		nxt_count = count_ff;
		nxt_remain = remain_ff;
		nxt_push = 1'b0;
		nxt_entry = entry_ff;
		nxt_rd_strobe = 1'b0;
		nxt_overrun = overrun_ff;
		nxt_oen = sel_low;
		if (!sel_low) begin
			// Partial bytes and an unfinished command are dropped
			nxt_state = sras_pkg::ST_ADDR;
			nxt_bitcnt = sras_pkg::BIT_FIRST;
		end else if (sel_fall) begin
			nxt_state = sras_pkg::ST_ADDR;
			nxt_bitcnt = sras_pkg::BIT_FIRST;
			nxt_tx = {chan_status[3], chan_status[2]};
			nxt_overrun = 1'b0;
		end else if (sclk_rise) begin
			nxt_shin = byte_in[6:0];
			nxt_bitcnt = bitcnt_ff + 3'h1;
			if (bitcnt_ff == sras_pkg::BIT_LAST) begin
				unique case (state_ff)
					sras_pkg::ST_ADDR: begin
						nxt_addr = byte_in;
						nxt_state = sras_pkg::ST_CMD;
					end
					sras_pkg::ST_CMD: begin
						nxt_dir = byte_in[sras_pkg::CMD_DIR_BIT];
						nxt_mode = byte_in[sras_pkg::CMD_MODE_LSB +: 2];
						nxt_count = byte_in[sras_pkg::CMD_COUNT_LSB +: 5];
						nxt_remain = byte_in[sras_pkg::CMD_COUNT_LSB +: 5];
						// A zero count ends the frame right after the command
						nxt_state = (byte_in[sras_pkg::CMD_COUNT_LSB +: 5] == 5'h00) ?
							sras_pkg::ST_ADDR : sras_pkg::ST_DATA;
					end
					sras_pkg::ST_DATA: begin
						if (!dir_ff) begin
							if (fifo_in_ready) begin
								nxt_push = 1'b1;
								nxt_entry.addr = addr_ff;
								// Reserved registers only ever see zero
								nxt_entry.data = sras_pkg::is_reserved(addr_ff) ?
									8'h00 : byte_in;
							end else begin
								nxt_overrun = 1'b1;
							end
						end
						nxt_addr = addr_ff + sras_pkg::step_of(mode_ff);
						if (count_ff != sras_pkg::COUNT_UNLIMITED) begin
							nxt_remain = remain_ff - 5'h01;
							if (remain_ff == sras_pkg::COUNT_LAST) begin
								nxt_state = sras_pkg::ST_ADDR;
							end
						end
					end
				endcase
			end
		end else if (sclk_fall) begin
			if (bitcnt_ff == sras_pkg::BIT_FIRST) begin
				unique case (state_ff)
					sras_pkg::ST_ADDR: nxt_tx = {chan_status[3], chan_status[2]};
					sras_pkg::ST_CMD: nxt_tx = {chan_status[1], chan_status[0]};
					sras_pkg::ST_DATA: begin
						if (dir_ff) begin
							nxt_tx = rd_data;
							nxt_rd_strobe = 1'b1;
						end else begin
							nxt_tx = sras_pkg::TX_RESET;
						end
					end
				endcase
			end else begin
				nxt_tx = {tx_ff[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			prev_sel_ff <= 1'b1;
			prev_sclk_ff <= 1'b0;
			state_ff <= sras_pkg::ST_ADDR;
			bitcnt_ff <= sras_pkg::BIT_FIRST;
			shin_ff <= 7'h00;
			tx_ff <= sras_pkg::TX_RESET;
			addr_ff <= sras_pkg::ADDR_RESET;
			dir_ff <= 1'b0;
			mode_ff <= sras_pkg::STEP_KEEP;
			count_ff <= sras_pkg::COUNT_RESET;
			remain_ff <= sras_pkg::COUNT_RESET;
			push_ff <= 1'b0;
			entry_ff <= '0;
			rd_strobe_ff <= 1'b0;
			overrun_ff <= 1'b0;
			oen_ff <= 1'b0;
		end else begin
			prev_sel_ff <= s_sel;
			prev_sclk_ff <= s_sclk;
			state_ff <= nxt_state;
			bitcnt_ff <= nxt_bitcnt;
			shin_ff <= nxt_shin;
			tx_ff <= nxt_tx;
			addr_ff <= nxt_addr;
			dir_ff <= nxt_dir;
			mode_ff <= nxt_mode;
			count_ff <= nxt_count;
			remain_ff <= nxt_remain;
			push_ff <= nxt_push;
			entry_ff <= nxt_entry;
			rd_strobe_ff <= nxt_rd_strobe;
			overrun_ff <= nxt_overrun;
			oen_ff <= nxt_oen;
		end
	end

	sras_fifo2 #(
		.WIDTH(16)
	) u_wr_buf (
		.clk(mclk),
		.rst(sys_rst),
		.in_valid(push_ff),
		.in_ready(fifo_in_ready),
		.in_data(entry_ff),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(fifo_out)
	);

	assign wr_entry = fifo_out;
	assign serial_out_pin = tx_ff[7];
	assign serial_out_en = oen_ff;
	assign frame_active = oen_ff;
	assign rd_addr = addr_ff;
	assign rd_strobe = rd_strobe_ff;
	assign wr_overrun = overrun_ff;

	a_out_enable: assert property (@(posedge mclk) disable iff (sys_rst)
		sel_low |=> oen_ff) else $error("output enable not following select");
	a_abort_resets: assert property (@(posedge mclk) disable iff (sys_rst)
		!sel_low |=> (state_ff == sras_pkg::ST_ADDR) && (bitcnt_ff == 3'h0))
		else $error("abort did not discard the frame");
	a_status_lead: assert property (@(posedge mclk) disable iff (sys_rst)
		sel_fall |=> tx_ff == $past({chan_status[3], chan_status[2]}))
		else $error("first status byte not loaded at frame start");
	a_sample_bit: assert property (@(posedge mclk) disable iff (sys_rst)
		(sel_low && !sel_fall && sclk_rise && bitcnt_ff != 3'h7) |=> shin_ff[0] == $past(s_sdi))
		else $error("input bit not sampled on rising edge");
	a_dir_decode: assert property (@(posedge mclk) disable iff (sys_rst)
		(sel_low && !sel_fall && sclk_rise && bitcnt_ff == 3'h7 && state_ff == sras_pkg::ST_CMD)
		|=> dir_ff == $past(s_sdi)) else $error("direction bit misdecoded");
	a_row_step: assert property (@(posedge mclk) disable iff (sys_rst)
		(sel_low && !sel_fall && sclk_rise && bitcnt_ff == 3'h7 && state_ff == sras_pkg::ST_DATA
		&& mode_ff == 2'h2) |=> addr_ff == $past(addr_ff) + 8'h20)
		else $error("address did not step by 32");
	a_write_commit: assert property (@(posedge mclk) disable iff (sys_rst)
		(sel_low && !sel_fall && sclk_rise && bitcnt_ff == 3'h7 && state_ff == sras_pkg::ST_DATA
		&& !dir_ff && fifo_in_ready) |=> push_ff ##1 !push_ff)
		else $error("write byte not committed once");
	a_read_load: assert property (@(posedge mclk) disable iff (sys_rst)
		(sel_low && !sel_fall && !sclk_rise && sclk_fall && bitcnt_ff == 3'h0
		&& state_ff == sras_pkg::ST_DATA && dir_ff) |=> rd_strobe_ff && tx_ff == $past(rd_data))
		else $error("read data not presented");
	a_write_zero: assert property (@(posedge mclk) disable iff (sys_rst)
		(sel_low && !sel_fall && !sclk_rise && sclk_fall && bitcnt_ff == 3'h0
		&& state_ff == sras_pkg::ST_DATA && !dir_ff) |=> tx_ff == 8'h00)
		else $error("write frame output not zero after status");
	a_count_end: assert property (@(posedge mclk) disable iff (sys_rst)
		(sel_low && !sel_fall && sclk_rise && bitcnt_ff == 3'h7 && state_ff == sras_pkg::ST_DATA
		&& remain_ff == 5'h01 && count_ff != 5'h1f) |=> state_ff == sras_pkg::ST_ADDR)
		else $error("frame did not end at byte count");
	a_keep_step: assert property (@(posedge mclk) disable iff (sys_rst)
		(sel_low && !sel_fall && sclk_rise && bitcnt_ff == 3'h7 && state_ff == sras_pkg::ST_DATA
		&& (mode_ff == 2'h0 || mode_ff == 2'h3)) |=> addr_ff == $past(addr_ff))
		else $error("address moved in keep mode");
	a_one_step: assert property (@(posedge mclk) disable iff (sys_rst)
		(sel_low && !sel_fall && sclk_rise && bitcnt_ff == 3'h7 && state_ff == sras_pkg::ST_DATA
		&& mode_ff == 2'h1) |=> addr_ff == $past(addr_ff) + 8'h01)
		else $error("address did not step by one");
	a_unlimited_stay: assert property (@(posedge mclk) disable iff (sys_rst)
		(sel_low && state_ff == sras_pkg::ST_DATA && count_ff == 5'h1f)
		|=> state_ff == sras_pkg::ST_DATA)
		else $error("unlimited frame ended while selected");
	a_strobe_single: assert property (@(posedge mclk) disable iff (sys_rst)
		rd_strobe_ff |=> !rd_strobe_ff) else $error("read strobe longer than one cycle");
	a_chain_status: assert property (@(posedge mclk) disable iff (sys_rst)
		(sel_low && !sel_fall && !sclk_rise && sclk_fall && bitcnt_ff == 3'h0
		&& state_ff == sras_pkg::ST_ADDR) |=> tx_ff == $past({chan_status[3], chan_status[2]}))
		else $error("chained frame did not restart with status");
	a_second_status: assert property (@(posedge mclk) disable iff (sys_rst)
		(sel_low && !sel_fall && !sclk_rise && sclk_fall && bitcnt_ff == 3'h0
		&& state_ff == sras_pkg::ST_CMD) |=> tx_ff == $past({chan_status[1], chan_status[0]}))
		else $error("second status byte not loaded");

	c_read_byte: cover property (@(posedge mclk) disable iff (sys_rst) rd_strobe_ff);
	c_write_byte: cover property (@(posedge mclk) disable iff (sys_rst) push_ff);
	c_abort_mid: cover property (@(posedge mclk) disable iff (sys_rst)
		(state_ff == sras_pkg::ST_DATA) ##1 !sel_low);
	c_unlimited: cover property (@(posedge mclk) disable iff (sys_rst)
		state_ff == sras_pkg::ST_DATA && count_ff == 5'h1f);
	c_zero_count: cover property (@(posedge mclk) disable iff (sys_rst)
		(state_ff == sras_pkg::ST_CMD) ##1 (state_ff == sras_pkg::ST_ADDR));
endmodule // sras_slave

`default_nettype wire

/* sras_master.sv */
/*
 * Behavioural serial master that faces the register access slave: drives select, serial clock
 * and data in mode 0, and samples the slave's output line.
 * Assumes the 200 MHz mclk of the bench; one serial bit lasts 16 mclk (80 ns).
 */
`timescale 1ns/10ps
`default_nettype none

module sras_master (
	input wire logic mclk,
	output logic select_low_pin,
	output logic serial_clock_pin,
	output logic serial_in_pin,
	input wire logic serial_out_pin
);
	initial begin
		select_low_pin = 1'b1;
		serial_clock_pin = 1'b0;
		serial_in_pin = 1'b0;
	end

	task automatic open_frame();
		@(posedge mclk);
		select_low_pin <= 1'b0;
		repeat (8) @(posedge mclk);
	endtask

	// Select rises only with the clock idle low; released data line shows the inverse
	task automatic close_frame();
		repeat (8) @(posedge mclk);
		select_low_pin <= 1'b1;
		serial_in_pin <= ~serial_in_pin;
		repeat (8) @(posedge mclk);
	endtask

	// Data set while the clock is low, output sampled at the rising edge
	task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
		rx = 8'h00;
		// Data changes at the edge where the clock falls, so one bit lasts 16 mclk
		for (int i = 7; i > 7 - nbits; i--) begin
			serial_in_pin <= tx[i];
			repeat (8) @(posedge mclk);
			rx[i] = serial_out_pin;
			serial_clock_pin <= 1'b1;
			repeat (8) @(posedge mclk);
			serial_clock_pin <= 1'b0;
		end
	endtask
endmodule // sras_master

`default_nettype wire

/* tb_spi_register_access_slave.sv */
/*
 * Self-checking bench of the serial register access slave with a behavioural master.
 * Assumes the register file answers rd_data = rd_addr ^ 0x5c and a 200 MHz mclk.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_spi_register_access_slave;
	typedef logic [7:0] sras_bytes_type [8];
	logic mclk;
	logic sys_rst;
	logic select_low_pin;
	logic serial_clock_pin;
	logic serial_in_pin;
	logic serial_out_pin;
	logic serial_out_en;
	logic frame_active;
	logic rd_strobe;
	logic wr_valid;
	logic wr_ready;
	logic wr_overrun;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	sras_pkg::sras_status_type [3:0] chan_status;
	sras_pkg::sras_wr_type wr_entry;
	sras_pkg::sras_wr_type wq[$];
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;
	int strobes = 0;

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	assign rd_data = rd_addr ^ 8'h5c;

	sras_slave DUT (.mclk(mclk), .sys_rst(sys_rst), .select_low_pin(select_low_pin),
		.serial_clock_pin(serial_clock_pin), .serial_in_pin(serial_in_pin),
		.serial_out_pin(serial_out_pin), .serial_out_en(serial_out_en),
		.frame_active(frame_active), .chan_status(chan_status), .rd_addr(rd_addr),
		.rd_data(rd_data), .rd_strobe(rd_strobe), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_entry(wr_entry), .wr_overrun(wr_overrun));

	sras_master far_end (.mclk(mclk), .select_low_pin(select_low_pin),
		.serial_clock_pin(serial_clock_pin), .serial_in_pin(serial_in_pin),
		.serial_out_pin(serial_out_pin));

	always @(posedge mclk) begin
		if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
			wq.push_back(wr_entry);
		end
		if (rd_strobe === 1'b1) begin
			strobes++;
		end
	end

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			stop_test();
		end
	end

	function automatic logic [7:0] rv(input logic [7:0] a);
		rv = a ^ 8'h5c;
	endfunction

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic take(input logic [15:0] exp);
		sras_pkg::sras_wr_type got;
		got = (wq.size() > 0) ? wq.pop_front() : 16'hxxxx;
		check("write entry", exp, got);
	endtask

	task automatic run_frame(input int n, input sras_bytes_type tx, input sras_bytes_type ex);
		logic [7:0] rx;
		far_end.open_frame();
		check("output enable", 16'h0003, {14'h0000, serial_out_en, frame_active});
		for (int i = 0; i < n; i++) begin
			far_end.xfer(tx[i], 8, rx);
			check("output byte", {8'h00, ex[i]}, {8'h00, rx});
		end
		far_end.close_frame();
		check("enable released", 16'h0000, {14'h0000, serial_out_en, frame_active});
	endtask

	task automatic stop_test();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Read two registers, step one; status bytes lead
	task automatic test_read_step();
		int base;
		base = strobes;
		run_frame(4, '{8'h10, 8'h13, 0, 0, 0, 0, 0, 0},
			'{8'ha5, 8'hc3, rv(8'h10), rv(8'h11), 0, 0, 0, 0});
		check("read strobes", 16'h0002, 16'(strobes - base));
	endtask

	// Three chained frames under one select: zero count, step one, no step
	task automatic test_chain();
		chan_status <= 16'h3c96;
		run_frame(8, '{8'h33, 8'h00, 8'h02, 8'h0b, 8'h00, 8'he0, 8'h09, 8'h00},
			'{8'h3c, 8'h96, 8'h3c, 8'h96, rv(8'h02), 8'h3c, 8'h96, rv(8'he0)});
	endtask

	// Unlimited count across the address wrap
	task automatic test_unlimited();
		run_frame(6, '{8'hfe, 8'hfb, 0, 0, 0, 0, 0, 0},
			'{8'h3c, 8'h96, rv(8'hfe), rv(8'hff), rv(8'h00), rv(8'h01), 0, 0});
	endtask

	// Write with step 32, then a reserved address that only takes zero
	task automatic test_write();
		int base;
		base = strobes;
		run_frame(4, '{8'h80, 8'h14, 8'h5a, 8'h3c, 0, 0, 0, 0},
			'{8'h3c, 8'h96, 8'h00, 8'h00, 0, 0, 0, 0});
		repeat (10) @(posedge mclk);
		take(16'h805a);
		take(16'ha03c);
		run_frame(3, '{8'h40, 8'h0a, 8'hff, 0, 0, 0, 0, 0},
			'{8'h3c, 8'h96, 8'h00, 0, 0, 0, 0, 0});
		repeat (10) @(posedge mclk);
		take(16'h4000);
		check("write strobes", 16'h0000, 16'(strobes - base));
	endtask

	// Consumer stalls: two entries held, third lost and flagged
	task automatic test_overrun();
		wr_ready <= 1'b0;
		run_frame(5, '{8'h05, 8'h18, 8'h11, 8'h22, 8'h33, 0, 0, 0},
			'{8'h3c, 8'h96, 8'h00, 8'h00, 8'h00, 0, 0, 0});
		check("stall state", 16'h0003, {14'h0000, wr_overrun, wr_valid});
		check("entries early", 16'h0000, 16'(wq.size()));
		@(posedge mclk);
		wr_ready <= 1'b1;
		repeat (10) @(posedge mclk);
		take(16'h0511);
		take(16'h0522);
		check("entries left", 16'h0000, {15'h0000, wr_valid});
	endtask

	// Select raised mid byte: nothing written; next frame clean, step code 3 keeps address
	task automatic test_abort();
		logic [7:0] rx;
		far_end.open_frame();
		far_end.xfer(8'h07, 8, rx);
		far_end.xfer(8'h08, 8, rx);
		far_end.xfer(8'haa, 4, rx);
		far_end.close_frame();
		repeat (20) @(posedge mclk);
		check("aborted writes", 16'h0000, {15'h0000, wr_valid});
		check("aborted queue", 16'h0000, 16'(wq.size()));
		run_frame(4, '{8'h07, 8'h17, 0, 0, 0, 0, 0, 0},
			'{8'h3c, 8'h96, rv(8'h07), rv(8'h07), 0, 0, 0, 0});
		check("overrun cleared", 16'h0000, {15'h0000, wr_overrun});
	endtask

	initial begin
		sys_rst = 1'b1;
		wr_ready = 1'b1;
		chan_status = 16'ha5c3;
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge mclk);
		test_read_step();
		test_chain();
		test_unlimited();
		test_write();
		test_overrun();
		test_abort();
		stop_test();
	end
endmodule // tb_spi_register_access_slave

`default_nettype wire
